// ==== src/dlw_monitor.sv ====
// dlw_monitor: limit warnings, output routing and frequency bypass
// assumes measured values and commands synchronous to i_clk
//
// Behaviour
// - low-current warning while current is below its limit, limit resets to 0 A.
// - high-current warning while current is above its high-current limit.
// - all six warnings inactive while ramping after start, after stop, stopped.
// - comparisons enabled only once output frequency reaches resulting reference.
// - any warning can drive the digital signal output and the relay.
// - low-frequency warning below limit; limit 0 up to high limit, resets 0 Hz.
// - high-frequency warning above limit; max and reset 132 Hz, 1000 Hz range.
// - low-feedback warning below limit; limit minimum to high limit, negative reset.
// - high-feedback warning above limit; limit low limit to maximum, positive reset.
// - bypass bandwidth up to 100 Hz, zero off, centred on each bypass frequency.
// - two bypass frequencies 0 to 1000 Hz, reset 0 Hz, mark avoided frequencies.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ns
module dlw_monitor
   import dlw_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_run,
   input wire logic [15:0] i_out_current,
   input wire logic [15:0] i_out_freq,
   input wire logic [15:0] i_ref_freq,
   input wire logic signed [31:0] i_feedback,
   input wire logic [15:0] i_cmd_freq,
   output logic [31:0] o_rdata,
   output logic o_irq,
   output logic [5:0] o_warn,
   output logic o_armed,
   output logic o_signal_out,
   output logic o_relay,
   output logic [15:0] o_cmd_freq
);

   // -------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------
   function automatic logic route(input logic [5:0] w, input logic [2:0] s);
      logic r;
      r = 1'b0;
      if (s != 3'd0 && s <= 3'd6) begin
         r = w[s - 3'd1];
      end
      return r;
   endfunction

   function automatic logic [15:0] clamp16(input logic [15:0] v,
      input logic [15:0] lo, input logic [15:0] hi);
      logic [15:0] r;
      r = v;
      if (r > hi) begin
         r = hi;
      end
      if (r < lo) begin
         r = lo;
      end
      return r;
   endfunction

   function automatic logic signed [31:0] clamp32(
      input logic signed [31:0] v, input logic signed [31:0] lo,
      input logic signed [31:0] hi);
      logic signed [31:0] r;
      r = v;
      if (r > hi) begin
         r = hi;
      end
      if (r < lo) begin
         r = lo;
      end
      return r;
   endfunction

   function automatic logic [15:0] bypass(input logic [15:0] f,
      input logic [15:0] c, input logic [15:0] bw);
      logic [16:0] half;
      logic [16:0] lo;
      logic [16:0] hi;
      logic [16:0] fx;
      logic [15:0] r;
      half = {2'b00, bw[15:1]};
      lo = ({1'b0, c} >= half) ? ({1'b0, c} - half) : 17'h0_0000;
      hi = {1'b0, c} + half;
      fx = {1'b0, f};
      r = f;
      if (bw != 16'h0000 && fx > lo && fx < hi) begin
         r = ((fx - lo) <= (hi - fx)) ? lo[15:0] : hi[15:0];
      end
      return r;
   endfunction

   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   dlw_regs_type r;
   dlw_regs_type next_r;

   logic [15:0] wd16;
   logic [15:0] fmax;
   logic [5:0] cmp;
   logic [5:0] clr;
   logic [15:0] band_c [0:1];
   logic [15:0] band_f [0:2];

   // -------------------------------------------------------------------
   // bypass bands, band 1 first and band 2 on its result
   // -------------------------------------------------------------------
   assign band_c[0] = r.bp1;
   assign band_c[1] = r.bp2;
   assign band_f[0] = i_cmd_freq;

   generate
      for (genvar g = 0; g < 2; g++) begin : g_band
         assign band_f[g + 1] = bypass(band_f[g], band_c[g], r.bp_bw);
      end
   endgenerate

   always_comb begin
      next_r = r;
      wd16 = (|i_wdata[31:16]) ? 16'hFFFF : i_wdata[15:0];
      fmax = r.range_high ? HF_MAX_HI : HF_MAX_LO;
      clr = 6'b00_0000;

      // -----------------------------------------------------------------
      // arming sequence
      // -----------------------------------------------------------------
      unique case (r.st)
         ST_STOP: begin
            if (i_run) begin
               next_r.st = ST_RAMP;
            end
         end
         ST_RAMP: begin
            if (!i_run) begin
               next_r.st = ST_STOP;
            end else if (i_out_freq >= i_ref_freq) begin
               next_r.st = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (!i_run) begin
               next_r.st = ST_STOP;
            end
         end
         default: begin
            next_r.st = ST_STOP;
         end
      endcase

      // -----------------------------------------------------------------
      // comparisons
      // -----------------------------------------------------------------
      cmp[W_LO_CUR] = i_out_current < r.lo_cur;
      cmp[W_HI_CUR] = i_out_current > r.hi_cur;
      cmp[W_LO_FREQ] = i_out_freq < r.lo_freq;
      cmp[W_HI_FREQ] = i_out_freq > r.hi_freq;
      cmp[W_LO_FB] = i_feedback < r.lo_fb;
      cmp[W_HI_FB] = i_feedback > r.hi_fb;
      next_r.warn = (next_r.st == ST_ARMED) ? cmp : 6'b00_0000;

      // -----------------------------------------------------------------
      // register writes
      // -----------------------------------------------------------------
      if (i_wr) begin
         unique case (i_addr)
            REG_CTRL: begin
               next_r.range_high = i_wdata[CTRL_RANGE_BIT];
               next_r.dso_sel = i_wdata[CTRL_DSO_LSB +: 3];
               next_r.relay_sel = i_wdata[CTRL_RELAY_LSB +: 3];
               if (!i_wdata[CTRL_RANGE_BIT] && r.hi_freq > HF_MAX_LO) begin
                  next_r.hi_freq = HF_MAX_LO;
               end
               if (!i_wdata[CTRL_RANGE_BIT] && r.lo_freq > HF_MAX_LO) begin
                  next_r.lo_freq = HF_MAX_LO;
               end
            end
            REG_LO_CUR: next_r.lo_cur = clamp16(wd16, 16'h0000, r.hi_cur);
            REG_HI_CUR: next_r.hi_cur = clamp16(wd16, r.lo_cur, 16'hFFFF);
            REG_LO_FREQ: next_r.lo_freq = clamp16(wd16, 16'h0000,
               r.hi_freq);
            REG_HI_FREQ: next_r.hi_freq = clamp16(wd16, r.lo_freq,
               fmax);
            REG_LO_FB: next_r.lo_fb = clamp32(i_wdata, FB_MIN,
               r.hi_fb);
            REG_HI_FB: next_r.hi_fb = clamp32(i_wdata, r.lo_fb,
               FB_MAX);
            REG_BP_BW: next_r.bp_bw = clamp16(wd16, 16'h0000,
               BP_BW_MAX);
            REG_BP1: next_r.bp1 = clamp16(wd16, 16'h0000,
               BP_FREQ_MAX);
            REG_BP2: next_r.bp2 = clamp16(wd16, 16'h0000,
               BP_FREQ_MAX);
            REG_STATUS: clr = i_wdata[5:0];
            REG_MASK: next_r.mask = i_wdata[5:0];
            default: begin
            end
         endcase
      end

      // -----------------------------------------------------------------
      // interrupt status, a new rising warning wins over a clear
      // -----------------------------------------------------------------
      next_r.status = (r.status & ~clr) | (next_r.warn & ~r.warn);
      next_r.irq = |(next_r.status & next_r.mask);

      // -----------------------------------------------------------------
      // register reads, data one cycle after the strobe
      // -----------------------------------------------------------------
      next_r.rdata = 32'h0000_0000;
      if (i_rd) begin
         unique case (i_addr)
            REG_CTRL: begin
               next_r.rdata[CTRL_RANGE_BIT] = r.range_high;
               next_r.rdata[CTRL_DSO_LSB +: 3] = r.dso_sel;
               next_r.rdata[CTRL_RELAY_LSB +: 3] = r.relay_sel;
            end
            REG_LO_CUR: next_r.rdata[15:0] = r.lo_cur;
            REG_HI_CUR: next_r.rdata[15:0] = r.hi_cur;
            REG_LO_FREQ: next_r.rdata[15:0] = r.lo_freq;
            REG_HI_FREQ: next_r.rdata[15:0] = r.hi_freq;
            REG_LO_FB: next_r.rdata = r.lo_fb;
            REG_HI_FB: next_r.rdata = r.hi_fb;
            REG_BP_BW: next_r.rdata[15:0] = r.bp_bw;
            REG_BP1: next_r.rdata[15:0] = r.bp1;
            REG_BP2: next_r.rdata[15:0] = r.bp2;
            REG_STATUS: next_r.rdata[5:0] = r.status;
            REG_MASK: next_r.rdata[5:0] = r.mask;
            REG_STATE: begin
               next_r.rdata[5:0] = r.warn;
               next_r.rdata[10:8] = r.st;
            end
            default: begin
            end
         endcase
      end

      // -----------------------------------------------------------------
      // output routing and bypass
      // -----------------------------------------------------------------
      next_r.sig_out = route(next_r.warn, r.dso_sel);
      next_r.relay = route(next_r.warn, r.relay_sel);
      next_r.cmd_freq = band_f[2];
   end

   // -------------------------------------------------------------------
   // registers
   // -------------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         r <= '0;
         r.st <= ST_STOP;
         r.lo_cur <= LO_CUR_RST;
         r.hi_cur <= HI_CUR_RST;
         r.lo_freq <= LO_FREQ_RST;
         r.hi_freq <= HI_FREQ_RST;
         r.lo_fb <= LO_FB_RST;
         r.hi_fb <= HI_FB_RST;
         r.bp_bw <= BP_RST;
         r.bp1 <= BP_RST;
         r.bp2 <= BP_RST;
      end else begin
         r <= next_r;
      end
   end

   assign o_rdata = r.rdata;
   assign o_irq = r.irq;
   assign o_warn = r.warn;
   assign o_armed = r.st[2];
   assign o_signal_out = r.sig_out;
   assign o_relay = r.relay;
   assign o_cmd_freq = r.cmd_freq;

endmodule

// ==== src/dlw_pkg.sv ====
// dlw_pkg: constants, register map and types of the limit warning monitor
// assumes currents in 0.1 A, frequencies in 0.1 Hz, feedback in 0.001 units
package dlw_pkg;

   // -------------------------------------------------------------------
   // register indices on the plain register port
   // -------------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_LO_CUR = 8'h01;
   localparam logic [7:0] REG_HI_CUR = 8'h02;
   localparam logic [7:0] REG_LO_FREQ = 8'h03;
   localparam logic [7:0] REG_HI_FREQ = 8'h04;
   localparam logic [7:0] REG_LO_FB = 8'h05;
   localparam logic [7:0] REG_HI_FB = 8'h06;
   localparam logic [7:0] REG_BP_BW = 8'h07;
   localparam logic [7:0] REG_BP1 = 8'h08;
   localparam logic [7:0] REG_BP2 = 8'h09;
   localparam logic [7:0] REG_STATUS = 8'h0A;
   localparam logic [7:0] REG_MASK = 8'h0B;
   localparam logic [7:0] REG_STATE = 8'h0C;

   // -------------------------------------------------------------------
   // control field positions
   // -------------------------------------------------------------------
   localparam int CTRL_RANGE_BIT = 0;
   localparam int CTRL_DSO_LSB = 4;
   localparam int CTRL_RELAY_LSB = 8;

   // -------------------------------------------------------------------
   // warning bit positions
   // -------------------------------------------------------------------
   localparam int W_LO_CUR = 0;
   localparam int W_HI_CUR = 1;
   localparam int W_LO_FREQ = 2;
   localparam int W_HI_FREQ = 3;
   localparam int W_LO_FB = 4;
   localparam int W_HI_FB = 5;

   // -------------------------------------------------------------------
   // limits and reset values
   // -------------------------------------------------------------------
   localparam logic [15:0] LO_CUR_RST = 16'h0000;
   localparam logic [15:0] HI_CUR_RST = 16'hFFFF;
   localparam logic [15:0] LO_FREQ_RST = 16'h0000;
   localparam logic [15:0] HF_MAX_LO = 16'h0528;
   localparam logic [15:0] HF_MAX_HI = 16'h2710;
   localparam logic [15:0] HI_FREQ_RST = 16'h0528;
   localparam logic signed [31:0] FB_MIN = -32'sh05F5_E100;
   localparam logic signed [31:0] FB_MAX = 32'sh05F5_E100;
   localparam logic signed [31:0] LO_FB_RST = -32'sh003D_0900;
   localparam logic signed [31:0] HI_FB_RST = 32'sh003D_0900;
   localparam logic [15:0] BP_BW_MAX = 16'h03E8;
   localparam logic [15:0] BP_FREQ_MAX = 16'h2710;
   localparam logic [15:0] BP_RST = 16'h0000;

   // -------------------------------------------------------------------
   // types
   // -------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_STOP = 3'b001,
      ST_RAMP = 3'b010,
      ST_ARMED = 3'b100
   } dlw_state_type;

   typedef struct packed {
      dlw_state_type st;
      logic range_high;
      logic [2:0] dso_sel;
      logic [2:0] relay_sel;
      logic [15:0] lo_cur;
      logic [15:0] hi_cur;
      logic [15:0] lo_freq;
      logic [15:0] hi_freq;
      logic signed [31:0] lo_fb;
      logic signed [31:0] hi_fb;
      logic [15:0] bp_bw;
      logic [15:0] bp1;
      logic [15:0] bp2;
      logic [5:0] warn;
      logic [5:0] status;
      logic [5:0] mask;
      logic [31:0] rdata;
      logic irq;
      logic sig_out;
      logic relay;
      logic [15:0] cmd_freq;
   } dlw_regs_type;

endpackage

// ==== test/dlw_monitor_chk.sv ====
// dlw_monitor_chk: concurrent checks on the monitor's ports
// assumes it is bound into every dlw_monitor instance
`timescale 1ns/1ns
module dlw_monitor_chk
   import dlw_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_run,
   input wire logic [15:0] i_out_freq,
   input wire logic [15:0] i_ref_freq,
   input wire logic [5:0] o_warn,
   input wire logic o_armed,
   input wire logic o_signal_out,
   input wire logic o_relay
);
   // --------------------------------------------------------------
   // routing selects shadowed from control writes
   // --------------------------------------------------------------
   logic [2:0] dso;
   logic [2:0] rly;
   logic ctrl_wr;
   assign ctrl_wr = i_wr && (i_addr == REG_CTRL);
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         dso <= 3'h0;
         rly <= 3'h0;
      end else if (ctrl_wr) begin
         dso <= i_wdata[6:4];
         rly <= i_wdata[10:8];
      end
   end
   function automatic logic pick(input logic [2:0] s, input logic [5:0] w);
      return (s >= 3'h1 && s <= 3'h6) ? w[s - 3'h1] : 1'b0;
   endfunction
   // --------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   sequence s_stop;
      o_armed ##0 !i_run;
   endsequence
   sequence s_idle;
      !o_armed ##0 (o_warn == 6'h00);
   endsequence
   AST_SUPPRESS: assert property (o_warn != 6'h00 |-> o_armed)
      else $error("warning while not armed");
   AST_ARM: assert property (!o_armed && !(i_run &&
      i_out_freq >= i_ref_freq) |=> !o_armed)
      else $error("armed before reference reached");
   AST_STOP: assert property (s_stop |=> s_idle)
      else $error("warnings kept after stop");
   AST_CUR: assert property (!(o_warn[0] && o_warn[1]))
      else $error("both current warnings");
   AST_FREQ: assert property (!(o_warn[2] && o_warn[3]))
      else $error("both frequency warnings");
   AST_FB: assert property (!(o_warn[4] && o_warn[5]))
      else $error("both feedback warnings");
   AST_DSO: assert property (!$past(ctrl_wr) |->
      o_signal_out == pick($past(dso), o_warn))
      else $error("signal output routing wrong");
   AST_RELAY: assert property (!$past(ctrl_wr) |->
      o_relay == pick($past(rly), o_warn))
      else $error("relay routing wrong");
endmodule
bind dlw_monitor dlw_monitor_chk i_dlw_monitor_chk (.i_clk, .i_reset,
   .i_addr, .i_wdata, .i_wr, .i_run, .i_out_freq, .i_ref_freq, .o_warn,
   .o_armed, .o_signal_out, .o_relay);

// ==== test/dlw_drive_model.sv ====
// dlw_drive_model: drive core ramping output frequency
// assumes the bench drives run and reference on the same clock
`timescale 1ns/1ns
module dlw_drive_model
(
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_run,
   input wire logic [15:0] i_ref_freq,
   output logic [15:0] o_out_freq
);
   localparam logic [15:0] STEP = 16'h0064;
   logic [15:0] goal;
   assign goal = i_run ? i_ref_freq : 16'h0000;
   // ramps toward the reference, down to zero when stopped
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_out_freq <= 16'h0000;
      end else if (o_out_freq + STEP <= goal) begin
         o_out_freq <= o_out_freq + STEP;
      end else if (o_out_freq >= goal + STEP) begin
         o_out_freq <= o_out_freq - STEP;
      end else begin
         o_out_freq <= goal;
      end
   end
endmodule

// ==== test/tb_top.sv ====
// tb_top: self-checking bench for the limit warning monitor
// assumes a 20 MHz clock and the drive model supplying output frequency
`timescale 1ns/1ns
module tb_top
   import dlw_pkg::*;
;
   logic clk, rst, wr_s, rd_s, run, irq, armed, sig, relay;
   logic [7:0] addr;
   logic [31:0] wdata, rdata;
   logic signed [31:0] fb;
   logic [15:0] cur, ofreq, ref_f, cmd, ocmd;
   logic [5:0] warn;
   int n_fail = 0;
   int n_checks = 0;
   dlw_drive_model i_dlw_drive_model (.i_clk(clk), .i_reset(rst),
      .i_run(run), .i_ref_freq(ref_f), .o_out_freq(ofreq));
   dlw_monitor i_dlw_monitor (.i_clk(clk), .i_reset(rst), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .i_run(run),
      .i_out_current(cur), .i_out_freq(ofreq), .i_ref_freq(ref_f),
      .i_feedback(fb), .i_cmd_freq(cmd), .o_rdata(rdata), .o_irq(irq),
      .o_warn(warn), .o_armed(armed), .o_signal_out(sig),
      .o_relay(relay), .o_cmd_freq(ocmd));
   always #25 clk = ~clk;
   // --------------------------------------------------------------
   // shared tasks
   // --------------------------------------------------------------
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task automatic wait_warn(input int b, input logic v);
      int k;
      k = 0;
      #1;
      while (warn[b] !== v && k < 100) begin
         @(posedge clk);
         #1 k++;
      end
      chk({31'h0, warn[b]}, {31'h0, v});
   endtask
   task automatic cmd_chk(input logic [15:0] f, input logic [15:0] e);
      @(posedge clk);
      cmd <= f;
      @(posedge clk);
      #1 chk({16'h0, ocmd}, {16'h0, e});
   endtask
   // --------------------------------------------------------------
   // scenarios
   // --------------------------------------------------------------
   task automatic t_bypass;
      rd_chk(REG_STATE, 32'h0000_0100);
      wr(REG_BP_BW, 32'h0000_0064);
      wr(REG_BP1, 32'h0000_01F4);
      wr(REG_BP2, 32'h0000_0320);
      cmd_chk(16'h01E0, 16'h01C2);
      cmd_chk(16'h01F4, 16'h01C2);
      cmd_chk(16'h0212, 16'h0226);
      cmd_chk(16'h0316, 16'h02EE);
      cmd_chk(16'h0258, 16'h0258);
      wr(REG_BP_BW, 32'h0000_0000);
      cmd_chk(16'h01E0, 16'h01E0);
      $display("test bypass done");
   endtask
   task automatic t_arm;
      @(posedge clk);
      fb <= 32'sh0050_0000;
      ref_f <= 16'h01F4;
      run <= 1'b1;
      repeat (3) begin
         @(posedge clk);
         #1 chk({26'h0, warn}, 32'h0);
      end
      wait_warn(W_HI_FB, 1'b1);
      chk({31'h0, armed}, 32'h1);
      @(posedge clk) fb <= 32'sh0000_0000;
      wait_warn(W_HI_FB, 1'b0);
      wr(REG_LO_CUR, 32'h0000_0032);
      @(posedge clk) cur <= 16'h0028;
      wait_warn(W_LO_CUR, 1'b1);
      @(posedge clk) cur <= 16'h003C;
      wait_warn(W_LO_CUR, 1'b0);
      wr(REG_HI_CUR, 32'h0000_0064);
      @(posedge clk) cur <= 16'h0078;
      wait_warn(W_HI_CUR, 1'b1);
      $display("test arming done");
   endtask
   task automatic t_route;
      wr(REG_CTRL, 32'h0000_0620);
      @(posedge clk);
      #1 chk({30'h0, sig, relay}, 32'h0000_0002);
      @(posedge clk) fb <= 32'sh0050_0000;
      wait_warn(W_HI_FB, 1'b1);
      chk({31'h0, relay}, 32'h1);
      wr(REG_MASK, 32'h0000_0002);
      @(posedge clk);
      #1 chk({31'h0, irq}, 32'h1);
      wr(REG_STATUS, 32'h0000_0002);
      @(posedge clk);
      #1 chk({31'h0, irq}, 32'h0);
      @(posedge clk) fb <= -32'sh003D_0901;
      wait_warn(W_LO_FB, 1'b1);
      chk({31'h0, relay}, 32'h0);
      $display("test routing done");
   endtask
   task automatic t_freq;
      wr(REG_LO_FREQ, 32'h0000_0190);
      @(posedge clk) ref_f <= 16'h012C;
      wait_warn(W_LO_FREQ, 1'b1);
      @(posedge clk) ref_f <= 16'h0578;
      wait_warn(W_HI_FREQ, 1'b1);
      chk({31'h0, warn[W_LO_FREQ]}, 32'h0);
      @(posedge clk) run <= 1'b0;
      @(posedge clk);
      #1 chk({25'h0, armed, warn}, 32'h0);
      rd_chk(REG_STATE, 32'h0000_0100);
      $display("test frequency and stop done");
   endtask
   task automatic t_clamp;
      rd_chk(REG_HI_FREQ, 32'h0000_0528);
      wr(REG_HI_FREQ, 32'h0000_3000);
      rd_chk(REG_HI_FREQ, 32'h0000_0528);
      wr(REG_CTRL, 32'h0000_0001);
      wr(REG_HI_FREQ, 32'h0001_0000);
      rd_chk(REG_HI_FREQ, 32'h0000_2710);
      wr(REG_LO_FREQ, 32'h0000_1F40);
      wr(REG_CTRL, 32'h0000_0000);
      rd_chk(REG_LO_FREQ, 32'h0000_0528);
      rd_chk(REG_HI_FREQ, 32'h0000_0528);
      rd_chk(REG_HI_FB, 32'h003D_0900);
      wr(REG_LO_FB, 32'h8000_0000);
      rd_chk(REG_LO_FB, 32'hFA0A_1F00);
      wr(REG_BP_BW, 32'h0000_FFFF);
      rd_chk(REG_BP_BW, 32'h0000_03E8);
      $display("test limit clamps done");
   endtask
   // --------------------------------------------------------------
   // main sequence and watchdog
   // --------------------------------------------------------------
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      {wr_s, rd_s, run, addr, wdata, fb, cur, ref_f, cmd} = '0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_bypass();
      t_arm();
      t_route();
      t_freq();
      t_clamp();
      complete_run();
   end
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      complete_run();
   end
endmodule
